// *** bench/socfg_prog_model.sv ***
// Programmer model on the configuration link.
// Assumes the bank takes one-cycle strobes on rising mclk.
module socfg_prog_model (
    input wire logic mclk,
    input wire logic [socfg_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid,
    output socfg_pkg::socfg_req_t req,
    output logic ram_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import socfg_pkg::*;
    initial begin
        req = '0;
        ram_mode = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        req <= '0;
        #1;
        d = rvalid ? rdata : 8'hXX;
    endtask : rd
    task automatic ram(input logic on);
        @(posedge mclk);
        ram_mode <= on;
    endtask : ram
endmodule : socfg_prog_model

// *** bench/socfg_regs_monitor.sv ***
// Checker for the configuration register bank.
// Sees only the bank's ports; bound to every instance of the bank.
module socfg_regs_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ram_mode,
    input wire socfg_pkg::socfg_req_t req,
    input wire socfg_pkg::socfg_cfg_t cfg,
    input wire logic [socfg_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic bank_one_open,
    input wire logic bank_two_open,
    input wire logic comparator_output,
    input wire logic driver_fault,
    input wire logic second_logic_output_o,
    input wire logic second_logic_output_oe,
    input wire logic third_logic_output_o,
    input wire logic third_logic_output_oe
);
    import socfg_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_key_rd; req.rd && req.addr == OFS_BANK_ONE_KEY |=> rvalid && rdata == READ_ZERO; endproperty
    a_key_rd: assert property (p_key_rd) else $error("key read not zero");
    property p_open1; req.wr && req.addr == OFS_BANK_ONE_KEY && req.wdata == ACCESS_KEY && ram_mode ##1 ram_mode
        |=> bank_one_open; endproperty
    a_open1: assert property (p_open1) else $error("bank one not opened");
    property p_open2; req.wr && req.addr == OFS_BANK_TWO_KEY && req.wdata == ACCESS_KEY && ram_mode ##1 ram_mode
        |=> bank_two_open; endproperty
    a_open2: assert property (p_open2) else $error("bank two not opened");
    property p_wrong1; req.wr && req.addr == OFS_BANK_ONE_KEY && req.wdata != ACCESS_KEY && ram_mode
        |=> ##1 !bank_one_open; endproperty
    a_wrong1: assert property (p_wrong1) else $error("bank one open after wrong key");
    property p_shut; !ram_mode |=> !bank_one_open && !bank_two_open; endproperty
    a_shut: assert property (p_shut) else $error("bank open outside RAM mode");
    property p_thr1; req.wr && req.addr == OFS_THRESHOLD_ONE && bank_one_open
        |=> ##1 cfg.first_threshold_code == $past(req.wdata[5:0], 2); endproperty
    a_thr1: assert property (p_thr1) else $error("threshold one wrong");
    property p_thr2; req.wr && req.addr == OFS_THRESHOLD_TWO && bank_one_open
        |=> ##1 {cfg.comparator_invert, cfg.stretch_polarity, cfg.second_threshold_code} == $past(req.wdata, 2);
    endproperty
    a_thr2: assert property (p_thr2) else $error("threshold two byte wrong");
    property p_drv; req.wr && req.addr == OFS_OUTPUT_DRIVER && bank_two_open
        |=> ##1 {cfg.pwm_duty_two[8], cfg.pwm_duty_one[8], cfg.driver_current_limit, cfg.driver_pull_select,
        cfg.driver_sense, cfg.driver_topology} == $past(req.wdata, 2); endproperty
    a_drv: assert property (p_drv) else $error("driver byte wrong");
    property p_lo2; (cfg.second_logic_out_mode[2:1] == 2'h1 && $stable(comparator_output) && $stable(cfg))[*5]
        |-> second_logic_output_oe == (comparator_output ^ cfg.comparator_invert ^ cfg.second_logic_out_mode[0]);
    endproperty
    a_lo2: assert property (p_lo2) else $error("comparator mode output wrong");
    property p_lo2s; ($stable(cfg) && cfg.second_logic_out_mode inside {3'h0, 3'h1, 3'h5, 3'h6, 3'h7})[*3]
        |-> second_logic_output_oe == (cfg.second_logic_out_mode != 3'h1); endproperty
    a_lo2s: assert property (p_lo2s) else $error("static mode output wrong");
    property p_flt; (cfg.second_logic_out_mode == 3'h4 && $stable(driver_fault) && $stable(cfg))[*5]
        |-> second_logic_output_oe == driver_fault; endproperty
    a_flt: assert property (p_flt) else $error("fault flag wrong");
    property p_lo3; $stable(cfg)[*3] |-> third_logic_output_oe == !cfg.third_logic_out_level
        && !third_logic_output_o && !second_logic_output_o; endproperty
    a_lo3: assert property (p_lo3) else $error("third output wrong");
endmodule : socfg_regs_monitor

bind socfg_regs socfg_regs_monitor i_mon (.mclk, .rst, .ram_mode, .req, .cfg, .rdata, .rvalid, .bank_one_open,
    .bank_two_open, .comparator_output, .driver_fault, .second_logic_output_o, .second_logic_output_oe,
    .third_logic_output_o, .third_logic_output_oe);

// *** bench/socfg_regs_tb_top.sv ***
// Testbench for the configuration register bank.
// Assumes the programmer model drives the register port and RAM mode.
module socfg_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import socfg_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic comparator_output = 1'b0;
    logic driver_fault = 1'b0;
    logic ram_mode, rvalid, bank_one_open, bank_two_open, e;
    logic second_logic_output_o, second_logic_output_oe, third_logic_output_o, third_logic_output_oe;
    socfg_req_t req;
    socfg_cfg_t cfg;
    logic [7:0] rdata, d;
    logic [7:0] ofs[8] = '{8'h14, 8'h15, 8'h17, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E};
    logic [7:0] dv[3] = '{8'h00, 8'h4D, 8'hB2};
    int n_fail = 0;
    int check_count = 0;
    always #5 mclk = ~mclk;
    socfg_regs i_dut (.mclk, .rst, .ram_mode, .req, .cfg, .rdata, .rvalid, .bank_one_open, .bank_two_open,
        .comparator_output, .driver_fault, .second_logic_output_o, .second_logic_output_oe,
        .third_logic_output_o, .third_logic_output_oe);
    socfg_prog_model i_prog (.mclk, .rdata, .rvalid, .req, .ram_mode);
    task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        i_prog.rd(a, d);
        chk("rdata", {1'b0, d}, {1'b0, x});
    endtask : rdchk
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        foreach (ofs[i]) rdchk(ofs[i], 8'h00);
        rdchk(8'h16, 8'h00);
        i_prog.wr(8'h14, 8'h3F);
        rdchk(8'h14, 8'h00);
        i_prog.ram(1'b1);
        i_prog.wr(8'h19, 8'h01);
        i_prog.wr(8'h17, 8'h34);
        i_prog.wr(8'h1E, 8'h34);
        rdchk(8'h19, 8'h00);
        chk("open1", {8'h00, bank_one_open}, 9'h001);
        chk("open2", {8'h00, bank_two_open}, 9'h001);
        i_prog.wr(8'h14, 8'hFF);
        i_prog.wr(8'h15, 8'hC5);
        rdchk(8'h14, 8'h3F);
        rdchk(8'h15, 8'hC5);
        chk("inv", {7'h00, cfg.comparator_invert, cfg.stretch_polarity}, 9'h003);
        foreach (dv[i]) begin
            i_prog.wr(8'h19, dv[i]);
            rdchk(8'h19, dv[i]);
            chk("topo", {7'h00, cfg.driver_topology}, {7'h00, dv[i][1:0]});
        end
        i_prog.wr(8'h1A, 8'hA5);
        i_prog.wr(8'h1B, 8'h5A);
        repeat (2) @(posedge mclk);
        chk("duty1", cfg.pwm_duty_one, 9'h0A5);
        chk("duty2", cfg.pwm_duty_two, 9'h15A);
        for (int m = 0; m < 16; m++) begin
            i_prog.wr(8'h1C, 8'(m));
            for (int c = 0; c < 2; c++) begin
                comparator_output <= c[0];
                driver_fault <= c[0];
                repeat (6) @(posedge mclk);
                case (m[2:0])
                    3'h1: e = 1'b0;
                    3'h2: e = ~c[0];
                    3'h3, 3'h4: e = c[0];
                    default: e = 1'b1;
                endcase
                chk("lo2", {8'h00, second_logic_output_oe}, {8'h00, e});
                chk("lo3", {8'h00, third_logic_output_oe}, {8'h00, ~m[3]});
            end
        end
        i_prog.wr(8'h1C, 8'hFB);
        rdchk(8'h1C, 8'h0B);
        i_prog.wr(8'h17, 8'h35);
        repeat (2) @(posedge mclk);
        chk("open1", {8'h00, bank_one_open}, 9'h000);
        i_prog.ram(1'b0);
        repeat (2) @(posedge mclk);
        chk("open2", {8'h00, bank_two_open}, 9'h000);
        conclude();
    end
endmodule : socfg_regs_tb_top

// *** logic/socfg_pkg.sv ***
// Package for the sensor driver configuration register bank.
// Holds register offsets, field positions, reset values, keys and carrier types.
package socfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] OFS_THRESHOLD_ONE = 8'h14;
    localparam logic [7:0] OFS_THRESHOLD_TWO = 8'h15;
    localparam logic [7:0] OFS_BANK_ONE_KEY = 8'h17;
    localparam logic [7:0] OFS_OUTPUT_DRIVER = 8'h19;
    localparam logic [7:0] OFS_PWM_ONE_LOW = 8'h1A;
    localparam logic [7:0] OFS_PWM_TWO_LOW = 8'h1B;
    localparam logic [7:0] OFS_LOGIC_OUTPUTS = 8'h1C;
    localparam logic [7:0] OFS_BANK_TWO_KEY = 8'h1E;

    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_KEY = 8'h35;
    localparam logic [7:0] ACCESS_KEY = 8'h34;
    localparam logic [7:0] READ_ZERO = 8'h00;

    localparam int THR_LSB = 0;
    localparam int THR_MSB = 5;
    localparam int POS_CMP_INVERT = 7;
    localparam int POS_STRETCH_POL = 6;
    localparam int POS_PWM_TWO_MSB = 7;
    localparam int POS_PWM_ONE_MSB = 6;
    localparam int POS_CURRENT_LIMIT = 5;
    localparam int PULL_LSB = 3;
    localparam int PULL_MSB = 4;
    localparam int POS_SENSE = 2;
    localparam int TOPO_LSB = 0;
    localparam int TOPO_MSB = 1;
    localparam int POS_LO3_LEVEL = 3;
    localparam int LO2_LSB = 0;
    localparam int LO2_MSB = 2;
    localparam int LOGIC_USED_W = 4;

    typedef enum logic [1:0] {
        SOCFG_PULL_NONE = 2'h0,
        SOCFG_PULL_UP = 2'h1,
        SOCFG_PULL_DOWN = 2'h2,
        SOCFG_PULL_RSVD = 2'h3
    } socfg_pull_t;

    typedef enum logic [1:0] {
        SOCFG_TOPO_HIGH_SIDE = 2'h0,
        SOCFG_TOPO_LOW_SIDE = 2'h1,
        SOCFG_TOPO_PUSH_PULL = 2'h2,
        SOCFG_TOPO_RSVD = 2'h3
    } socfg_topo_t;

    typedef enum logic [2:0] {
        SOCFG_LO2_STATIC_LOW = 3'h0,
        SOCFG_LO2_STATIC_OPEN = 3'h1,
        SOCFG_LO2_CMP_FOLLOW = 3'h2,
        SOCFG_LO2_CMP_INVERSE = 3'h3,
        SOCFG_LO2_FAULT_FLAG = 3'h4
    } socfg_lo2_mode_t;

    // Register access request from the link layer.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } socfg_req_t;

    // Decoded configuration handed to the analog and driver sections.
    typedef struct packed {
        logic [5:0] first_threshold_code;
        logic [5:0] second_threshold_code;
        logic comparator_invert;
        logic stretch_polarity;
        logic [8:0] pwm_duty_one;
        logic [8:0] pwm_duty_two;
        logic driver_current_limit;
        logic [1:0] driver_pull_select;
        logic driver_sense;
        logic [1:0] driver_topology;
        logic third_logic_out_level;
        logic [2:0] second_logic_out_mode;
    } socfg_cfg_t;

endpackage : socfg_pkg

// *** logic/socfg_regs.sv ***
// Configuration register bank of the sensor output driver, second comparator and output banks.
// Assumes a link decoder on mclk presenting one-cycle read and write strobes and a RAM-mode level;
// comparator and fault levels arrive from analog circuitry and are synchronised here.
//
// Function
// - First threshold code in bits 5:0.
// - Second threshold code in next register 5:0.
// - Bit 7 set inverts comparator output.
// - Bit 6 picks positive or negative stretching.
// - Key 0x34 in RAM mode opens bank one.
// - Key 0x34 in RAM mode opens bank two.
// - Duty two: MSB bit 7, low byte 0x1B.
// - Duty one: MSB bit 6, low byte 0x1A.
// - Bit 5 selects 100mA or 200mA limit.
// - Bits 4:3 select none, pullup, pulldown.
// - Bit 2 selects normally-open or normally-closed.
// - Bits 1:0 select high-side, low-side, push-pull.
// - Bit 3 sets third output static level.
// - Mode 000 low, 001 open.
// - Mode 010: on while comparator high.
// - Mode 011: on while comparator low.
// - Mode 100: pulls low on driver fault.
module socfg_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ram_mode,
    input wire socfg_pkg::socfg_req_t req,
    output socfg_pkg::socfg_cfg_t cfg,
    output logic [socfg_pkg::DATA_W-1:0] rdata,
    output logic rvalid,
    output logic bank_one_open,
    output logic bank_two_open,
    input wire logic comparator_output,
    input wire logic driver_fault,
    output logic second_logic_output_o,
    output logic second_logic_output_oe,
    output logic third_logic_output_o,
    output logic third_logic_output_oe
);
    import socfg_pkg::*;

    logic [DATA_W-1:0] threshold_one_cfg;
    logic [DATA_W-1:0] threshold_two_polarity_cfg;
    logic [DATA_W-1:0] output_driver_cfg;
    logic [DATA_W-1:0] pwm_duty_one_low;
    logic [DATA_W-1:0] pwm_duty_two_low;
    logic [DATA_W-1:0] logic_outputs_cfg;
    logic [DATA_W-1:0] bank_one_key;
    logic [DATA_W-1:0] bank_two_key;
    logic [1:0] cmp_sync;
    logic [1:0] fault_sync;
    logic cmp_effective;
    logic next_lo2_oe;
    logic wr_one;
    logic wr_two;

    // Tells whether an offset lies in the comparator bank (one) or the output bank (two).
    function automatic logic in_bank_one(input logic [ADDR_W-1:0] a);
        in_bank_one = (a == OFS_THRESHOLD_ONE) || (a == OFS_THRESHOLD_TWO);
    endfunction : in_bank_one

    function automatic logic in_bank_two(input logic [ADDR_W-1:0] a);
        in_bank_two = (a == OFS_OUTPUT_DRIVER) || (a == OFS_PWM_ONE_LOW) ||
            (a == OFS_PWM_TWO_LOW) || (a == OFS_LOGIC_OUTPUTS);
    endfunction : in_bank_two

    // A bank accepts configuration writes only while open.
    assign wr_one = req.wr && bank_one_open && in_bank_one(req.addr);
    assign wr_two = req.wr && bank_two_open && in_bank_two(req.addr);

    // Key registers are written only in RAM mode; any value other than the key closes the bank.
    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_one_key <= RST_KEY;
            bank_two_key <= RST_KEY;
        end else if (req.wr && ram_mode) begin
            if (req.addr == OFS_BANK_ONE_KEY) begin
                bank_one_key <= req.wdata;
            end
            if (req.addr == OFS_BANK_TWO_KEY) begin
                bank_two_key <= req.wdata;
            end
        end
    end

    // Access is granted while the key is held and RAM mode stays active.
    always_ff @(posedge mclk) begin
        if (rst) begin
            bank_one_open <= 1'b0;
            bank_two_open <= 1'b0;
        end else begin
            bank_one_open <= ram_mode && (bank_one_key == ACCESS_KEY);
            bank_two_open <= ram_mode && (bank_two_key == ACCESS_KEY);
        end
    end

    // Comparator bank storage; unused upper threshold bits are not stored.
    always_ff @(posedge mclk) begin
        if (rst) begin
            threshold_one_cfg <= RST_CFG;
            threshold_two_polarity_cfg <= RST_CFG;
        end else if (wr_one) begin
            if (req.addr == OFS_THRESHOLD_ONE) begin
                threshold_one_cfg <= {2'h0, req.wdata[THR_MSB:THR_LSB]};
            end else begin
                threshold_two_polarity_cfg <= req.wdata;
            end
        end
    end

    // Output bank storage; unused upper bits of the logic output register are not stored.
    always_ff @(posedge mclk) begin
        if (rst) begin
            output_driver_cfg <= RST_CFG;
            pwm_duty_one_low <= RST_CFG;
            pwm_duty_two_low <= RST_CFG;
            logic_outputs_cfg <= RST_CFG;
        end else if (wr_two) begin
            unique case (req.addr)
                OFS_OUTPUT_DRIVER: output_driver_cfg <= req.wdata;
                OFS_PWM_ONE_LOW: pwm_duty_one_low <= req.wdata;
                OFS_PWM_TWO_LOW: pwm_duty_two_low <= req.wdata;
                default: logic_outputs_cfg <= {4'h0, req.wdata[LOGIC_USED_W-1:0]};
            endcase
        end
    end

    // Read port: stored registers read back, key registers and unmapped offsets read zero.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= READ_ZERO;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                unique case (req.addr)
                    OFS_THRESHOLD_ONE: rdata <= threshold_one_cfg;
                    OFS_THRESHOLD_TWO: rdata <= threshold_two_polarity_cfg;
                    OFS_OUTPUT_DRIVER: rdata <= output_driver_cfg;
                    OFS_PWM_ONE_LOW: rdata <= pwm_duty_one_low;
                    OFS_PWM_TWO_LOW: rdata <= pwm_duty_two_low;
                    OFS_LOGIC_OUTPUTS: rdata <= logic_outputs_cfg;
                    default: rdata <= READ_ZERO;
                endcase
            end
        end
    end

    // Decoded configuration fields, registered for the analog and driver sections.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            cfg.first_threshold_code <= threshold_one_cfg[THR_MSB:THR_LSB];
            cfg.second_threshold_code <= threshold_two_polarity_cfg[THR_MSB:THR_LSB];
            cfg.comparator_invert <= threshold_two_polarity_cfg[POS_CMP_INVERT];
            cfg.stretch_polarity <= threshold_two_polarity_cfg[POS_STRETCH_POL];
            cfg.pwm_duty_one <= {output_driver_cfg[POS_PWM_ONE_MSB], pwm_duty_one_low};
            cfg.pwm_duty_two <= {output_driver_cfg[POS_PWM_TWO_MSB], pwm_duty_two_low};
            cfg.driver_current_limit <= output_driver_cfg[POS_CURRENT_LIMIT];
            cfg.driver_pull_select <= output_driver_cfg[PULL_MSB:PULL_LSB];
            cfg.driver_sense <= output_driver_cfg[POS_SENSE];
            cfg.driver_topology <= output_driver_cfg[TOPO_MSB:TOPO_LSB];
            cfg.third_logic_out_level <= logic_outputs_cfg[POS_LO3_LEVEL];
            cfg.second_logic_out_mode <= logic_outputs_cfg[LO2_MSB:LO2_LSB];
        end
    end

    // Analog levels pass two flip-flops before any logic reads them.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmp_sync <= 2'h0;
            fault_sync <= 2'h0;
        end else begin
            cmp_sync <= {cmp_sync[0], comparator_output};
            fault_sync <= {fault_sync[0], driver_fault};
        end
    end

    // The polarity bit applies to the comparator before the logic output uses it.
    assign cmp_effective = cmp_sync[1] ^ threshold_two_polarity_cfg[POS_CMP_INVERT];

    // Open-drain second output: enable high means the pin is pulled low, which is the on state.
    always_comb begin
        unique case (logic_outputs_cfg[LO2_MSB:LO2_LSB])
            SOCFG_LO2_STATIC_LOW: next_lo2_oe = 1'b1;
            SOCFG_LO2_STATIC_OPEN: next_lo2_oe = 1'b0;
            SOCFG_LO2_CMP_FOLLOW: next_lo2_oe = cmp_effective;
            SOCFG_LO2_CMP_INVERSE: next_lo2_oe = !cmp_effective;
            SOCFG_LO2_FAULT_FLAG: next_lo2_oe = fault_sync[1];
            default: next_lo2_oe = 1'b1;
        endcase
    end

    // Open-drain pins only ever drive low; a high level is the released pin.
    always_ff @(posedge mclk) begin
        if (rst) begin
            second_logic_output_o <= 1'b0;
            second_logic_output_oe <= 1'b1;
            third_logic_output_o <= 1'b0;
            third_logic_output_oe <= 1'b1;
        end else begin
            second_logic_output_o <= 1'b0;
            second_logic_output_oe <= next_lo2_oe;
            third_logic_output_o <= 1'b0;
            third_logic_output_oe <= !logic_outputs_cfg[POS_LO3_LEVEL];
        end
    end

endmodule : socfg_regs
